//--- hdl/csw_pkg.sv
// constants, codes and types shared by the clocked serial word port
package csw_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
  localparam logic [7:0] OFS_STATE      = 8'h08;
  localparam logic [7:0] OFS_DBR_BASE   = 8'h20;
  localparam int         DBR_IDX_LSB    = 2;
  localparam int         DBR_IDX_MSB    = 4;
  localparam int         DBR_SEL_LSB    = 5;

  // serial_control_one fields
  localparam int RUN_BIT_POS   = 7;
  localparam int ABORT_BIT_POS = 6;
  localparam int MODE_MSB      = 5;
  localparam int MODE_LSB      = 3;
  localparam int CSEL_MSB      = 2;
  localparam int CSEL_LSB      = 0;

  // serial_control_two fields
  localparam int WCNT_MSB = 2;
  localparam int WCNT_LSB = 0;

  // serial_state_reg fields
  localparam int BUSY_POS  = 7;
  localparam int SHIFT_POS = 6;

  // transfer modes
  localparam logic [2:0] MODE_TX4   = 3'h2;
  localparam logic [2:0] MODE_TXRX8 = 3'h4;
  localparam logic [2:0] MODE_RX8   = 3'h5;
  localparam logic [2:0] MODE_RX4   = 3'h6;

  // clock select codes
  localparam logic [2:0] CSEL_MAX_INT = 3'h5;
  localparam logic [2:0] CSEL_UNUSED  = 3'h6;
  localparam logic [2:0] CSEL_EXT     = 3'h7;

  // divider exponents of main_clock_freq per clock select code 000..101
  localparam logic [3:0] CLK_EXP_0 = 4'hd;
  localparam logic [3:0] CLK_EXP_1 = 4'h8;
  localparam logic [3:0] CLK_EXP_2 = 4'h7;
  localparam logic [3:0] CLK_EXP_3 = 4'h6;
  localparam logic [3:0] CLK_EXP_4 = 4'h5;
  localparam logic [3:0] CLK_EXP_5 = 4'h4;

  // least external clock pulse, in main_clock_freq periods
  localparam int EXT_PULSE_FC_CYC = 16;

  // word geometry
  localparam logic [2:0] LAST_BIT_4 = 3'h3;
  localparam logic [2:0] LAST_BIT_8 = 3'h7;
  localparam logic [7:0] DUMMY_WORD = 8'hff;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_WAIT  = 2'b10
  } csw_state_t;

  typedef struct packed {
    csw_state_t      state;
    logic            run;
    logic [2:0]      mode;
    logic [2:0]      csel;
    logic [2:0]      wcnt;
    logic [7:0][7:0] data_buffer_regs;
    logic [2:0]      widx;
    logic [2:0]      bidx;
    logic [7:0]      tx_sh;
    logic [7:0]      rx_sh;
    logic            need_svc;
    logic            dummy;
    logic            sck_o;
    logic [11:0]     div;
    logic            s1;
    logic            s2;
    logic            s3;
    logic            so;
    logic            irq;
    logic [31:0]     prdata;
  } csw_st_t;

endpackage

//--- hdl/csw_port.sv
// clocked serial word port: apb registers, shift clock, word shifter
//
// Overview of operation
// - shift clock comes from internal divider or external pin per clock select.
// - codes 000..101 pick six divided rates, 111 external, 110 unused.
// - internal clock drives the shift clock pin high when a transfer starts.
// - internal clock freezes and next shift waits until buffers are serviced.
// - outgoing bits change on the falling edge of the shift clock.
// - incoming bits are captured on the rising edge of the shift clock.
// - 4-bit words use the low nibble; received upper nibble is zero.
// - each word goes least significant bit first.
// - up to 8 words per round; done pulse once the count is moved.
// - software loads buffers then sets run; device then shifts words out.
// - transmit raises done after last counted word when buffer empties.
// - internal transmit waits for new data; any word write releases it.
// - a write to an unused buffer also releases the transmit wait.
// - clearing run ends after current words; abort ends at once.
// - external clock, run still set without new data: dummy word then end.
// - receive stores each word into next buffer; done after counted words.
// - internal rx4/rx8 receive waits until any buffer, used or unused, is read; txrx8 waits for a write.
// - external receive with unread data drops the word and ends reception.
// - receive run clear stores current word then ends; abort discards it.
// - modes 010 tx4, 100 txrx8, 101 rx8, 110 rx4; others reserved.
// - busy flag reads 1 while transferring, 0 once terminated.
// - word count 000..111 means 1..8 words, buffers used from lowest upward.
`timescale 1ns/10ps
module csw_port
  import csw_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic              sck_i,
  output      logic              sck_o,
  output      logic              sck_oe_n,
  input  wire logic              si,
  output      logic              so,
  output      logic              transfer_done_irq
);

  csw_st_t    q_reg;
  csw_st_t    q_next;

  logic       setup_ph;
  logic       acc_ph;
  logic       wr_acc;
  logic       rd_acc;
  logic       dbr_hit;
  logic [2:0] dbr_idx;
  logic       addr_hit;
  logic       internal;
  logic       is_tx;
  logic       is_rx;
  logic       four;
  logic [2:0] last_bit;
  logic [3:0] exp_sel;
  logic [11:0] half_cnt;
  logic       fall_ev;
  logic       rise_ev;
  logic       last_w;
  logic       ovr;
  logic       stop_now;
  logic       start_ev;
  logic       abort_ev;
  logic       store_ev;
  logic       ovr_ev;
  logic [7:0] load_word;
  logic [7:0] pick_word;
  logic [7:0] rx_word;
  logic [2:0] wr_mode;
  logic [2:0] wr_csel;
  logic       wr_mode_ok;

  assign setup_ph = psel & ~penable;
  assign acc_ph   = psel & penable;
  assign wr_acc   = acc_ph & pwrite;
  assign rd_acc   = acc_ph & ~pwrite;
  assign dbr_hit  = paddr[ADDR_W-1:DBR_SEL_LSB] == OFS_DBR_BASE[ADDR_W-1:DBR_SEL_LSB];
  assign dbr_idx  = paddr[DBR_IDX_MSB:DBR_IDX_LSB];
  assign addr_hit = dbr_hit | (paddr == OFS_CTRL_ONE) | (paddr == OFS_CTRL_TWO) | (paddr == OFS_STATE);

  assign internal = q_reg.csel != CSEL_EXT;
  assign is_tx    = (q_reg.mode == MODE_TX4) | (q_reg.mode == MODE_TXRX8);
  assign is_rx    = (q_reg.mode == MODE_RX4) | (q_reg.mode == MODE_RX8) | (q_reg.mode == MODE_TXRX8);
  assign four     = (q_reg.mode == MODE_TX4) | (q_reg.mode == MODE_RX4);
  assign last_bit = four ? LAST_BIT_4 : LAST_BIT_8;

  assign wr_mode  = pwdata[MODE_MSB:MODE_LSB];
  assign wr_csel  = pwdata[CSEL_MSB:CSEL_LSB];
  assign wr_mode_ok = ((wr_mode == MODE_TX4) | (wr_mode == MODE_TXRX8) | (wr_mode == MODE_RX8)
                      | (wr_mode == MODE_RX4)) & (wr_csel != CSEL_UNUSED);

  always_comb
  begin
    case (q_reg.csel)
      3'h0:    exp_sel = CLK_EXP_0;
      3'h1:    exp_sel = CLK_EXP_1;
      3'h2:    exp_sel = CLK_EXP_2;
      3'h3:    exp_sel = CLK_EXP_3;
      3'h4:    exp_sel = CLK_EXP_4;
      default: exp_sel = CLK_EXP_5;
    endcase
  end

  // half a bit period, so one full sck period is 2^exp pclk cycles
  assign half_cnt = 12'((13'h1 << (exp_sel - 4'h1)) - 13'h1);

  always_comb
  begin
    q_next    = q_reg;
    q_next.irq = 1'b0;
    fall_ev   = 1'b0;
    rise_ev   = 1'b0;
    last_w    = 1'b0;
    ovr       = 1'b0;
    stop_now  = 1'b0;
    start_ev  = 1'b0;
    abort_ev  = 1'b0;
    store_ev  = 1'b0;
    ovr_ev    = 1'b0;
    load_word = q_reg.data_buffer_regs[q_reg.widx];
    pick_word = q_reg.tx_sh;
    rx_word   = q_reg.rx_sh;

    // two-stage sync then edge detect on the second stage
    q_next.s1 = sck_i;
    q_next.s2 = q_reg.s1;
    q_next.s3 = q_reg.s2;

    // any buffer write, used or not, releases the transmit wait
    if (wr_acc && dbr_hit && is_tx)
      q_next.need_svc = 1'b0;
    // any buffer read releases the receive wait in rx4 and rx8 modes only
    if (rd_acc && dbr_hit && is_rx && !is_tx)
      q_next.need_svc = 1'b0;
    if (wr_acc && dbr_hit)
      q_next.data_buffer_regs[dbr_idx] = pwdata[7:0];

    case (q_reg.state)
      ST_IDLE:
      begin
        q_next.sck_o = 1'b1;
      end
      ST_SHIFT:
      begin
        if (internal)
        begin
          if (q_reg.div == half_cnt)
          begin
            q_next.div   = '0;
            q_next.sck_o = ~q_reg.sck_o;
            fall_ev      = q_reg.sck_o;
            rise_ev      = ~q_reg.sck_o;
          end
          else
          begin
            q_next.div = q_reg.div + 12'h1;
          end
        end
        else
        begin
          fall_ev = q_reg.s3 & ~q_reg.s2;
          rise_ev = ~q_reg.s3 & q_reg.s2;
        end

        if (fall_ev && is_tx)
        begin
          // external clock with no fresh data sends a dummy word
          if (!internal && q_reg.need_svc && q_reg.widx == 3'h0)
          begin
            load_word     = DUMMY_WORD;
            q_next.dummy  = 1'b1;
          end
          if (q_reg.bidx == 3'h0)
          begin
            pick_word    = load_word;
            q_next.tx_sh = load_word;
          end
          q_next.so = pick_word[q_reg.bidx];
        end

        if (rise_ev)
        begin
          rx_word[q_reg.bidx] = si;
          q_next.rx_sh        = rx_word;
          if (q_reg.bidx != last_bit)
          begin
            q_next.bidx = q_reg.bidx + 3'h1;
          end
          else
          begin
            q_next.bidx = 3'h0;
            // count code n means n+1 words
            last_w = q_reg.widx == q_reg.wcnt;
            ovr    = is_rx && !internal && q_reg.need_svc;
            ovr_ev = ovr;
            if (is_rx && !ovr)
            begin
              store_ev = 1'b1;
              if (four)
                q_next.data_buffer_regs[q_reg.widx] = {NIBBLE_ZERO, rx_word[3:0]};
              else
                q_next.data_buffer_regs[q_reg.widx] = rx_word;
            end
            if (last_w && !ovr)
            begin
              q_next.irq      = 1'b1;
              q_next.need_svc = 1'b1;
              q_next.widx     = 3'h0;
            end
            else
            begin
              q_next.widx = q_reg.widx + 3'h1;
            end
            // run clear ends at a boundary, a dummy word ends at once
            stop_now = ovr | (is_rx & ~q_reg.run) | (last_w & ~q_reg.run) | q_reg.dummy;
            if (stop_now)
            begin
              q_next.state    = ST_IDLE;
              q_next.need_svc = 1'b0;
            end
            else if (internal && last_w)
            begin
              q_next.state = ST_WAIT;
            end
          end
        end
      end
      ST_WAIT:
      begin
        // sck holds high; count may be rewritten here
        if (!q_next.need_svc)
        begin
          q_next.state = ST_SHIFT;
          q_next.div   = '0;
        end
      end
      default:
      begin
        q_next.state = ST_IDLE;
      end
    endcase

    if (wr_acc && paddr == OFS_CTRL_TWO)
      q_next.wcnt = pwdata[WCNT_MSB:WCNT_LSB];

    if (wr_acc && paddr == OFS_CTRL_ONE)
    begin
      q_next.mode = wr_mode;
      q_next.csel = wr_csel;
      q_next.run  = pwdata[RUN_BIT_POS];
      // abort ends at once, word in progress discarded
      if (pwdata[ABORT_BIT_POS])
      begin
        abort_ev        = 1'b1;
        q_next.state    = ST_IDLE;
        q_next.sck_o    = 1'b1;
        q_next.need_svc = 1'b0;
        q_next.bidx     = 3'h0;
        q_next.widx     = 3'h0;
      end
      else if (pwdata[RUN_BIT_POS] && q_reg.state == ST_IDLE && wr_mode_ok)
      begin
        start_ev        = 1'b1;
        q_next.state    = ST_SHIFT;
        q_next.widx     = 3'h0;
        q_next.bidx     = 3'h0;
        q_next.div      = '0;
        q_next.sck_o    = 1'b1;
        q_next.need_svc = 1'b0;
        q_next.dummy    = 1'b0;
      end
    end

    // read data is latched in the setup phase so it comes from a flop
    if (setup_ph && !pwrite)
    begin
      q_next.prdata = '0;
      if (dbr_hit)
        q_next.prdata[7:0] = q_reg.data_buffer_regs[dbr_idx];
      else if (paddr == OFS_STATE)
      begin
        q_next.prdata[BUSY_POS]  = q_reg.state != ST_IDLE;
        q_next.prdata[SHIFT_POS] = q_reg.state == ST_SHIFT;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_reg       <= '0;
      q_reg.sck_o <= 1'b1;
      q_reg.s1    <= 1'b1;
      q_reg.s2    <= 1'b1;
      q_reg.s3    <= 1'b1;
      q_reg.so    <= 1'b1;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  // no wait states: access phase always completes
  assign pready            = acc_ph;
  assign pslverr           = acc_ph & ~addr_hit;
  assign prdata            = q_reg.prdata;
  assign sck_o             = q_reg.sck_o;
  assign sck_oe_n          = ~internal;
  assign so                = q_reg.so;
  assign transfer_done_irq = q_reg.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_sck_high: assert property (start_ev && internal |=> sck_o && q_reg.state == ST_SHIFT)
    else $error("sck not high at transfer start");
  a_ext_pin_input: assert property (q_reg.csel == CSEL_EXT |-> sck_oe_n)
    else $error("sck driven while external clock chosen");
  a_wait_frozen: assert property (q_reg.state == ST_WAIT && $past(q_reg.state) == ST_WAIT |-> sck_o && $stable(sck_o))
    else $error("shift clock moved during wait");
  a_so_on_fall: assert property (q_reg.state != ST_IDLE && !fall_ev |=> $stable(so))
    else $error("serial out changed off the falling edge");
  a_nibble_zero: assert property (store_ev && four |=> q_reg.data_buffer_regs[$past(q_reg.widx)][7:4] == NIBBLE_ZERO)
    else $error("upper nibble not cleared on 4-bit receive");
  a_irq_single: assert property (transfer_done_irq |=> !transfer_done_irq)
    else $error("done pulse longer than one cycle");
  a_abort_idle: assert property (abort_ev |=> q_reg.state == ST_IDLE ##1 q_reg.state == ST_IDLE || start_ev)
    else $error("abort did not end the transfer");
  a_overrun_end: assert property (ovr_ev |=> q_reg.state == ST_IDLE && !transfer_done_irq)
    else $error("external overrun did not cancel reception");
  a_wait_release: assert property (q_reg.state == ST_WAIT && !q_next.need_svc && !abort_ev |=> q_reg.state == ST_SHIFT)
    else $error("wait not released by buffer service");
  a_busy_read: assert property (setup_ph && !pwrite && paddr == OFS_STATE ##1 acc_ph
                                |-> prdata[BUSY_POS] == ($past(q_reg.state) != ST_IDLE))
    else $error("busy flag does not match transfer state");

  c_round_done: cover property (transfer_done_irq && is_tx);
  c_rx_wait:    cover property (q_reg.state == ST_WAIT && is_rx ##[1:50] q_reg.state == ST_SHIFT);
  c_ext_ovr:    cover property (ovr_ev);
  c_dummy_end:  cover property (q_reg.dummy && q_reg.state == ST_SHIFT ##[1:500] q_reg.state == ST_IDLE);

endmodule

//--- tb/csw_peer.sv
// behavioural serial peer sharing the shift clock with the port
`timescale 1ns/10ps
module csw_peer
#(
  parameter int PULSE = 20
)
(
  input  wire logic        pclk,
  input  wire logic        clr,
  input  wire logic        sck,
  input  wire logic        so,
  input  wire logic        ext_go,
  input  wire logic [6:0]  ext_n,
  input  wire logic [63:0] pdata,
  output      logic        si,
  output      logic        sck_drv,
  output      logic [63:0] rx_bits,
  output      logic [7:0]  nbits
);
  logic sck_q;
  int   ph;
  int   left;

  initial
  begin
    sck_q = 1'b1;
    si = 1'b1;
    sck_drv = 1'b1;
    rx_bits = 64'h0;
    nbits = 8'h00;
    ph = 0;
    left = 0;
  end

  always @(posedge pclk)
  begin
    sck_q <= sck;
    if (clr)
    begin
      nbits <= 8'h00;
      rx_bits <= 64'h0;
    end
    else if (sck && !sck_q)
    begin
      rx_bits <= {so, rx_bits[63:1]};
      nbits <= nbits + 8'h01;
    end
    if (!sck && sck_q)
      si <= pdata[nbits[5:0]];
    if (ext_go)
    begin
      left <= 2 * ext_n;
      ph <= 0;
    end
    // each level lasts above 16 cycles
    else if (left > 0)
    begin
      ph <= (ph == PULSE - 1) ? 0 : ph + 1;
      if (ph == PULSE - 1)
      begin
        sck_drv <= !sck_drv;
        left <= left - 1;
      end
    end
  end
endmodule

//--- tb/test_clocked_serial_word_port.sv
// self-checking random bench for the clocked serial word port
`timescale 1ns/10ps
module test_clocked_serial_word_port;
  import csw_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, clr, ext_go, err;
  logic        si, so, sck_o, sck_oe_n, irq, pready, pslverr, sck_drv;
  logic [7:0]  paddr, nbits;
  logic [7:0]  bufv [8];
  logic [6:0]  ext_n;
  logic [31:0] pwdata, prdata, rd;
  logic [31:0] seed = 32'h1e34;
  logic [63:0] pdata, rx_bits;
  int          err_count, samples_checked, cyc, n;
  wire         sck_pin = sck_oe_n ? sck_drv : sck_o;

  csw_port u_csw_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_i(sck_pin),
    .sck_o(sck_o), .sck_oe_n(sck_oe_n), .si(si), .so(so), .transfer_done_irq(irq));
  csw_peer u_csw_peer (.pclk(pclk), .clr(clr), .sck(sck_pin), .so(so), .ext_go(ext_go), .ext_n(ext_n),
    .pdata(pdata), .si(si), .sck_drv(sck_drv), .rx_bits(rx_bits), .nbits(nbits));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_sim();
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] ex);
    samples_checked++;
    if (got !== ex)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctrl(input logic run, input logic ab, input logic [2:0] md, input logic [2:0] cs);
    apb(1'b1, OFS_CTRL_ONE, {24'h0, run, ab, md, cs});
  endtask

  // mode and clock written while stopped
  task automatic start(input logic [2:0] md, input logic [2:0] cs);
    ctrl(1'b0, 1'b1, md, cs);
    ctrl(1'b1, 1'b0, md, cs);
  endtask

  task automatic busy(input string nm, input logic ex);
    apb(1'b0, OFS_STATE, 32'h0);
    chk(nm, rd[BUSY_POS], ex);
  endtask

  task automatic burst(input logic [6:0] nb);
    ext_n <= nb;
    ext_go <= 1'b1;
    @(posedge pclk);
    ext_go <= 1'b0;
  endtask

  task automatic wait_irq();
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (irq !== 1'b1 && n < 20000);
    chk("done_irq", irq, 64'h1);
  endtask

  task automatic xfer(input logic [2:0] md, input logic [2:0] cs, input logic [2:0] cnt);
    int          w;
    int          nw;
    int          k;
    logic [63:0] msk;
    logic [63:0] got;
    w = (md == MODE_TX4 || md == MODE_RX4) ? 4 : 8;
    nw = cnt + 1;
    msk = (64'h1 << w) - 64'h1;
    pdata = {xs(), xs()};
    ctrl(1'b0, 1'b1, md, cs);
    apb(1'b1, OFS_CTRL_TWO, {29'h0, cnt});
    for (k = 0; k < 8; k++)
    begin
      bufv[k] = 8'(xs());
      apb(1'b1, OFS_DBR_BASE + 8'(4 * k), {24'h0, bufv[k]});
    end
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    ctrl(1'b1, 1'b0, md, cs);
    if (cs == CSEL_EXT)
      burst(7'(w * nw));
    wait_irq();
    repeat (40) @(posedge pclk);
    got = rx_bits;
    chk("bit_count", nbits, 64'(w * nw));
    chk("sck_wait", sck_pin, 64'h1);
    busy("busy_wait", 1'b1);
    if (cs != CSEL_EXT && cnt != 3'h7 && md != MODE_TXRX8)
    begin
      apb(md == MODE_TX4, OFS_DBR_BASE + 8'h1c, 32'h0);
      repeat (60) @(posedge pclk);
      chk("wait_release", 64'(nbits != 8'(w * nw)), 64'h1);
    end
    if (cs == CSEL_EXT)
    begin
      // no fresh data before the next word
      burst(7'(w));
      repeat (w * 40 + 20) @(posedge pclk);
      if (md == MODE_TX4)
      begin
        chk("dummy_word", (rx_bits >> (64 - w)) & msk, msk);
        busy("dummy_end", 1'b0);
      end
      else
        busy("overrun_stop", 1'b0);
    end
    ctrl(1'b0, 1'b1, md, cs);
    busy("busy_abort", 1'b0);
    for (k = 0; k < nw; k++)
    begin
      if (md == MODE_TX4 || md == MODE_TXRX8)
        chk("tx_word", (got >> (64 - w * nw + w * k)) & msk, 64'(bufv[k]) & msk);
      if (md != MODE_TX4)
      begin
        apb(1'b0, OFS_DBR_BASE + 8'(4 * k), 32'h0);
        chk("rx_word", rd, (pdata >> (w * k)) & msk);
      end
    end
  endtask

  // ceiling well above the slowest clock code plus all rounds
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_count++;
      end_sim();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clr = 1'b0;
    ext_go = 1'b0;
    ext_n = 7'h00;
    pdata = 64'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    busy("busy_reset", 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {err, rd}, 64'h1_0000_0000);
    start(MODE_TX4, CSEL_UNUSED);
    busy("start_csel6", 1'b0);
    start(3'h0, 3'h5);
    busy("start_rsv_mode", 1'b0);
    for (int c = 0; c < 6; c++)
    begin
      start(MODE_TX4, 3'(c));
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
        if (n == 1) chk("sck_start", sck_o, 64'h1);
      end
      while (sck_o !== 1'b0 && n < 5000);
      // toggle is seen one edge after the edge that makes it
      chk("half_period", n, (64'h1 << (c == 0 ? 12 : 8 - c)) + 64'h1);
      chk("sck_drive", sck_oe_n, 64'h0);
      ctrl(1'b0, 1'b1, MODE_TX4, 3'(c));
    end
    xfer(MODE_TX4, 3'h5, 3'(xs()));
    xfer(MODE_RX8, 3'h4, 3'(xs()));
    xfer(MODE_RX4, 3'h5, 3'h7);
    xfer(MODE_TXRX8, 3'h5, 3'h0);
    xfer(MODE_TX4, CSEL_EXT, 3'(xs()));
    chk("sck_input", sck_oe_n, 64'h1);
    xfer(MODE_RX8, CSEL_EXT, 3'h1);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    start(MODE_TX4, 3'h5);
    ctrl(1'b0, 1'b0, MODE_TX4, 3'h5);
    wait_irq();
    busy("busy_stop", 1'b0);
    chk("stop_bits", nbits, 64'h8);
    end_sim();
  end
endmodule
